// File: src/ris_pkg.sv
// Package: register map, field layout and source codes of the input selector
package ris_pkg;

	// Register bus geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;

	// Register offsets (byte addresses, chosen for this block)
	localparam logic [3:0] ENC_SEL_OFF   = 4'h0;
	localparam logic [3:0] UART_SEL_OFF  = 4'h4;
	localparam logic [3:0] PIN_STAT_OFF  = 4'h8;
	localparam logic [3:0] ROUTE_OFF     = 4'hC;

	// Field layout of a selection register
	localparam int unsigned SEL_W       = 7;
	localparam int unsigned LO_FIELD_LSB = 0;
	localparam int unsigned HI_FIELD_LSB = 8;

	// Reset values
	localparam logic [15:0] ENC_SEL_RST  = 16'h0000;
	localparam logic [15:0] UART_SEL_RST = 16'h0000;

	// Writable bits of a selection register; bits 15 and 7 stay zero
	localparam logic [15:0] SEL_WMASK = 16'h7F7F;

	// Source codes in the selection table
	localparam logic [6:0] CODE_GND      = 7'h00;
	localparam logic [6:0] CODE_COMP_ONE   = 7'h01;
	localparam logic [6:0] CODE_COMP_TWO   = 7'h02;
	localparam logic [6:0] CODE_COMP_THREE = 7'h03;
	localparam logic [6:0] CODE_INDEX_ONE  = 7'h08;
	localparam logic [6:0] CODE_HOME_ONE   = 7'h09;
	localparam logic [6:0] CODE_INDEX_TWO  = 7'h0A;
	localparam logic [6:0] CODE_HOME_TWO   = 7'h0B;
	localparam logic [6:0] CODE_BIDIR64  = 7'h40;
	localparam logic [6:0] CODE_TOP      = 7'h7F;

	// Codes that map to nothing and read as ground (4-7, 12-15, 24-29,
	// 48, 53-59, 63); codes above 63 fall through to the pin index
	localparam logic [127:0] RESERVED_MAP =
		128'h0000_0000_0000_0000_8FE1_0000_3F00_F0F0;

	// Number of routed peripheral inputs
	localparam int unsigned N_ROUTES = 4;

endpackage

// File: src/ris_pin_sync.sv
// Module: two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module ris_pin_sync
	import ris_pkg::*;
#(
	parameter int unsigned WIDTH = 128
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= '0;
			sync_o  <= '0;
		end else begin
			meta_ff <= async_i;
			sync_o  <= meta_ff;
		end
	end

endmodule

// File: src/ris_source_mux.sv
// Module: decode one 7-bit selection code to a single source level
`timescale 1ns/1ns
module ris_source_mux
	import ris_pkg::*;
(
	input  wire logic [SEL_W-1:0] code_i,
	input  wire logic [127:0]     sources_i,
	output logic                  level_o
);

	// Ground and reserved codes read as zero; others index the table
	always_comb begin
		if (code_i == CODE_GND || RESERVED_MAP[code_i]) begin
			level_o = 1'b0;
		end else begin
			level_o = sources_i[code_i];
		end
	end

endmodule

// File: src/ris_selector.sv
// Module: remappable input selector with its register file
//
// Summary of operation
// - Code zero ties the peripheral input to ground.
// - Code one connects the peripheral input to comparator one output.
// - All-ones selects remap pin 127; codes 16 to 126 select numbered pins, except reserved 24-29, 48, 53-59 and 63.
// - Codes decode via fixed table; reserved codes read ground, avoid them.
// - Bits 15 and 7 of selection registers read zero, ignore writes.
// - UART two receive source is bits 6..0 of UART select register.
// - UART two clear-to-send source is bits 14..8 of that register.
// - Encoder phase A source is low field of encoder select register.
// - Encoder phase B source is high field of encoder select register.
`timescale 1ns/1ns
module ris_selector
	import ris_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	input  wire logic [127:16]     remap_pin_i,
	input  wire logic [2:0]        comparator_i,
	input  wire logic [1:0]        fault_index_i,
	input  wire logic [1:0]        fault_home_i,
	output logic                   encoder_phase_a_o,
	output logic                   encoder_phase_b_o,
	output logic                   uart_two_receive_o,
	output logic                   uart_two_clear_to_send_o
);

	logic [DATA_W-1:0] encoder_input_select_ff;
	logic [DATA_W-1:0] uart_two_input_select_ff;
	logic [127:0]      raw_sources;
	logic [127:0]      sync_sources;
	logic [N_ROUTES-1:0] route_level;
	logic [N_ROUTES-1:0] route_ff;
	logic [SEL_W-1:0]  route_code [N_ROUTES];
	logic [DATA_W-1:0] nxt_rdata;

	// Pack every pin and virtual source by code; unused slots stay low
	always_comb begin
		raw_sources = '0;
		raw_sources[127:16] = remap_pin_i;
		raw_sources[CODE_COMP_ONE] = comparator_i[0];
		raw_sources[CODE_COMP_TWO] = comparator_i[1];
		raw_sources[CODE_COMP_THREE] = comparator_i[2];
		raw_sources[CODE_INDEX_ONE] = fault_index_i[0];
		raw_sources[CODE_HOME_ONE] = fault_home_i[0];
		raw_sources[CODE_INDEX_TWO] = fault_index_i[1];
		raw_sources[CODE_HOME_TWO] = fault_home_i[1];
	end

	// Pins are asynchronous; sync all sources so latency is uniform
	ris_pin_sync #(
		.WIDTH (128)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   (raw_sources),
		.sync_o    (sync_sources)
	);

	// Encoder selection register, unused bits masked off
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			encoder_input_select_ff <= ENC_SEL_RST;
		end else if (reg_wr_i && reg_addr_i == ENC_SEL_OFF) begin
			encoder_input_select_ff <= reg_wdata_i & SEL_WMASK;
		end
	end

	// UART two selection register, unused bits masked off
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			uart_two_input_select_ff <= UART_SEL_RST;
		end else if (reg_wr_i && reg_addr_i == UART_SEL_OFF) begin
			uart_two_input_select_ff <= reg_wdata_i & SEL_WMASK;
		end
	end

	// Field extraction per routed input
	assign route_code[0] =
		encoder_input_select_ff[LO_FIELD_LSB +: SEL_W];
	assign route_code[1] =
		encoder_input_select_ff[HI_FIELD_LSB +: SEL_W];
	assign route_code[2] =
		uart_two_input_select_ff[LO_FIELD_LSB +: SEL_W];
	assign route_code[3] =
		uart_two_input_select_ff[HI_FIELD_LSB +: SEL_W];

	// One decoder per peripheral input
	for (genvar g = 0; g < N_ROUTES; g++) begin : g_route
		ris_source_mux u_mux (
			.code_i    (route_code[g]),
			.sources_i (sync_sources),
			.level_o   (route_level[g])
		);
	end

	// Register the routed levels so outputs come from flops
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			route_ff <= '0;
		end else begin
			route_ff <= route_level;
		end
	end

	assign encoder_phase_a_o        = route_ff[0];
	assign encoder_phase_b_o        = route_ff[1];
	assign uart_two_receive_o       = route_ff[2];
	assign uart_two_clear_to_send_o = route_ff[3];

	// Read mux; unmapped offsets read zero
	always_comb begin
		nxt_rdata = '0;
		case (reg_addr_i)
			ENC_SEL_OFF:  nxt_rdata = encoder_input_select_ff;
			UART_SEL_OFF: nxt_rdata = uart_two_input_select_ff;
			PIN_STAT_OFF: nxt_rdata = {12'h000, route_ff};
			ROUTE_OFF:    nxt_rdata = {12'h000, route_level};
			default:      nxt_rdata = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= nxt_rdata;
		end else begin
			reg_rdata_o <= '0;
		end
	end

endmodule

// File: bench/ris_periph_model.sv
// Model of the peripheral inputs that consume the routed levels
`timescale 1ns/1ns
module ris_periph_model (
	input  wire logic       sys_clk_i,
	input  wire logic [3:0] route_i,
	output logic      [3:0] seen_o
);
	// Peripherals sample on the system clock, one cycle late
	always_ff @(posedge sys_clk_i) begin
		seen_o <= route_i;
	end
endmodule

// File: bench/ris_selector_assertions.sv
// Checker: register and routing properties of the input selector
`timescale 1ns/1ns
module ris_selector_chk
	import ris_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [DATA_W-1:0] reg_rdata_o,
	input  wire logic [127:16]     remap_pin_i,
	input  wire logic [2:0]        comparator_i,
	input  wire logic              encoder_phase_a_o,
	input  wire logic              encoder_phase_b_o,
	input  wire logic              uart_two_receive_o
);
	logic [15:0] enc_ff;
	logic [15:0] uart_ff;
	// Shadow copies judge routing without looking inside
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			enc_ff <= 16'h0000;
			uart_ff <= 16'h0000;
		end else if (reg_wr_i && reg_addr_i == ENC_SEL_OFF) begin
			enc_ff <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == UART_SEL_OFF) begin
			uart_ff <= reg_wdata_i;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_unused_bits_zero: assert property (reg_rd_i && reg_addr_i[3] == 1'b0
		|=> !reg_rdata_o[15] && !reg_rdata_o[7]) else $error("unused bit set");
	chk_write_read_back: assert property (reg_wr_i && reg_addr_i == ENC_SEL_OFF
		##1 reg_rd_i && reg_addr_i == ENC_SEL_OFF
		|=> reg_rdata_o == ($past(reg_wdata_i, 2) & SEL_WMASK))
		else $error("readback wrong");
	chk_reset_ground: assert property ($rose(rst_b_i)
		|-> !encoder_phase_a_o && !encoder_phase_b_o && !uart_two_receive_o)
		else $error("output high after reset");
	chk_ground_code: assert property ((enc_ff[6:0] == CODE_GND)[*3]
		|-> !encoder_phase_a_o) else $error("ground code not low");
	chk_cmp_one_route: assert property (
		(enc_ff[14:8] == CODE_COMP_ONE && comparator_i[0])[*5]
		|-> encoder_phase_b_o) else $error("comparator not routed");
	chk_top_pin_route: assert property (
		(uart_ff[6:0] == CODE_TOP && remap_pin_i[127])[*5]
		|-> uart_two_receive_o) else $error("top pin not routed");
	chk_top_pin_low: assert property (
		(enc_ff[6:0] == CODE_TOP && !remap_pin_i[127])[*5]
		|-> !encoder_phase_a_o) else $error("top pin low not routed");
	chk_bidir_pin_route: assert property (
		(enc_ff[6:0] == CODE_BIDIR64 && remap_pin_i[64])[*5]
		|-> encoder_phase_a_o) else $error("pin 64 not routed");
endmodule
bind ris_selector ris_selector_chk u_ris_selector_chk (.*);

// File: bench/ris_selector_tb.sv
// Testbench: register access and routing tests of the input selector
`timescale 1ns/1ns
module ris_selector_tb
	import ris_pkg::*;
();
	localparam logic [15:0] MASK = 16'h8F9F; // Codes that route a source
	logic [6:0]   codes [16] = '{7'h01, 7'h7F, 7'h02, 7'h40, 7'h03, 7'h00,
		7'h04, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h10, 7'h18, 7'h30, 7'h3F, 7'h57};
	logic         clk = 1'b0;
	logic         rst_b = 1'b0;
	logic [3:0]   addr = 4'h0;
	logic [15:0]  wdata = 16'h0000;
	logic         wr_s = 1'b0;
	logic         rd_s = 1'b0;
	logic [15:0]  rdata;
	logic [127:0] src = '0;
	logic [3:0]   route;
	logic [3:0]   seen;
	logic [3:0]   exp;
	logic [15:0]  val;
	int           error_cnt = 0;
	int           n_tests = 0;
	initial forever #4 clk = ~clk;
	// Source index equals selection code
	ris_selector u_ris_selector (.sys_clk_i(clk), .rst_b_i(rst_b),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
		.reg_rd_i(rd_s), .reg_rdata_o(rdata), .remap_pin_i(src[127:16]),
		.comparator_i(src[3:1]), .fault_index_i({src[10], src[8]}),
		.fault_home_i({src[11], src[9]}), .encoder_phase_a_o(route[0]),
		.encoder_phase_b_o(route[1]), .uart_two_receive_o(route[2]),
		.uart_two_clear_to_send_o(route[3]));
	ris_periph_model u_ris_periph_model (.sys_clk_i(clk), .route_i(route),
		.seen_o(seen));
	task automatic chk(input string what, input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk("read data", rdata, e);
		@(posedge clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(ENC_SEL_OFF, ENC_SEL_RST);
		rd(UART_SEL_OFF, UART_SEL_RST);
		chk("routes", {12'h000, seen}, 16'h0000);
		$display("reset test done");
		wr(ENC_SEL_OFF, 16'hFFFF);
		rd(ENC_SEL_OFF, 16'h7F7F);
		wr(4'h2, 16'hFFFF);
		rd(4'h2, 16'h0000);
		$display("register test done");
		// Alternate fields so a crossed field shows up
		for (int k = 0; k < 16; k++) begin
			exp = {4{MASK[k]}} & (k[0] ? 4'b0101 : 4'b1010);
			val = k[0] ? {9'h000, codes[k]} : {1'b0, codes[k], 8'h00};
			src <= MASK[k] ? 128'h1 << codes[k] : '1;
			wr(ENC_SEL_OFF, val);
			@(posedge clk); // Gap lets the write strobe drop low between the two writes
			wr(UART_SEL_OFF, val);
			repeat (5) @(posedge clk);
			chk("routes", {12'h000, seen}, {12'h000, exp});
			rd(PIN_STAT_OFF, {12'h000, exp});
		end
		// Top pin low must reach phase A as low
		wr(ENC_SEL_OFF, {9'h000, CODE_TOP});
		src <= '0;
		repeat (6) @(posedge clk);
		chk("top pin low", {12'h000, seen}, 16'h0000);
		$display("code table test done");
		stop_test();
	end
endmodule
